// ### tb/cd_audio_output_path_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module audio_path_checker #(
  parameter int FAIL_CYC = 40
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  // pins
  input wire logic        q_read_done_i,
  input wire logic        frame_valid_i,
  input wire logic        frame_abs_sync_i,
  input wire logic [15:0] q_peak_o,
  input wire logic        error_flag_pin_o,
  input wire logic        error_flag_pin_oe_n_o,
  input wire logic        second_stage_fail_pin_o,
  input wire logic        dac_bclk_o,
  input wire logic        dac_ws_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [15:0] low_cnt_ff;
  // a pin stuck low would never end a pulse, so its length is counted
  always @(posedge clk_i)
  begin
    if (rst_i || second_stage_fail_pin_o)
      low_cnt_ff <= 16'h0000;
    else
      low_cnt_ff <= low_cnt_ff + 16'h0001;
  end
  sequence bus_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence fail_pulse;
    !second_stage_fail_pin_o [*8];
  endsequence
  // the first flag bit reaches the pin two edges after the frame strobe
  sequence flag_lead;
    ##1 (!error_flag_pin_o && error_flag_pin_oe_n_o == $past(frame_abs_sync_i, 2));
  endsequence
  ack_after_take_a: assert property (bus_take |=> ack_o) else $error("no ack");
  ack_single_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  ack_cause_a: assert property ($rose(ack_o) |-> $past(stb_i)) else $error("stray ack");
  read_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
  fail_min_a: assert property ($fell(second_stage_fail_pin_o) |-> fail_pulse)
    else $error("fail pulse short");
  fail_len_a: assert property (low_cnt_ff <= FAIL_CYC + 16)
    else $error("fail pulse long");
  peak_clear_a: assert property (q_read_done_i |=> q_peak_o == 16'h0)
    else $error("peak kept");
  flag_first_bit_a: assert property (frame_valid_i |=> flag_lead)
    else $error("first flag bit wrong");
  ws_on_fall_a: assert property ($changed(dac_ws_o) |-> $fell(dac_bclk_o))
    else $error("ws moved off edge");
endmodule // audio_path_checker
bind cd_audio_output_path audio_path_checker #(.FAIL_CYC(FAIL_CYC)) audio_path_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .dat_o(dat_o), .q_read_done_i(q_read_done_i), .q_peak_o(q_peak_o),
  .frame_valid_i(frame_valid_i), .frame_abs_sync_i(frame_abs_sync_i),
  .error_flag_pin_oe_n_o(error_flag_pin_oe_n_o),
  .error_flag_pin_o(error_flag_pin_o), .second_stage_fail_pin_o(second_stage_fail_pin_o),
  .dac_bclk_o(dac_bclk_o), .dac_ws_o(dac_ws_o));
`default_nettype wire

// ### tb/cd_audio_output_path_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cd_audio_output_path_map.vh"
module cd_audio_output_path_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we_i = 1'b0, smp_valid_i = 1'b0;
  logic        bad_i = 1'b0, frame_valid_i = 1'b0, abs_i = 1'b0, pre_i = 1'b0, qdone_i = 1'b0;
  logic [31:0] dat_i = 32'h0, dat_o, rdata;
  logic [15:0] smp_i = 16'h0, q_peak_o;
  logic [7:0]  adr_i = 8'h00;
  logic [2:0]  c2_i = 3'h0;
  logic [1:0]  c1_i = 2'h0;
  logic [23:0] word;
  logic        ack_o, fail_o, cfg5_o, bclk, ws, sdata, flag_oe_n, ef_o;
  logic [7:0]  fbits;
  int          failures = 0, tests_run = 0;
  // level command word, then expected gain
  logic [39:0] lv [5] = '{40'h0000000000, 40'h0000000120, 40'h0000780378,
                          40'h0000200320, 40'h0000000280};
  always #4 clk_i = ~clk_i;
  cd_audio_output_path #(.FAIL_CYC(40)) cd_audio_output_path_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(req), .stb_i(req), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .smp_valid_i(smp_valid_i),
    .smp_left_i(smp_i), .smp_right_i(smp_i), .smp_bad_left_i(bad_i), .smp_bad_right_i(bad_i),
    .frame_valid_i(frame_valid_i), .frame_abs_sync_i(abs_i), .frame_c1_i(c1_i),
    .frame_c2_i(c2_i), .q_preemph_i(pre_i), .q_read_done_i(qdone_i), .error_flag_pin_o(),
    .error_flag_pin_oe_n_o(flag_oe_n), .second_stage_fail_pin_o(fail_o),
    .q_peak_o(q_peak_o), .dac_bclk_o(bclk), .dac_ws_o(ws), .dac_data_o(sdata),
    .error_flag_output_o(ef_o), .config_pin_five_o(cfg5_o));
  dac_receiver_model dac_receiver_model_i (
    .bclk_i(bclk), .ws_i(ws), .data_i(sdata), .word_o(word));
  // ----------------------------------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rdata = dat_o;
    req <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic smp(input logic [15:0] v, input logic b);
    smp_i <= v;
    bad_i <= b;
    smp_valid_i <= 1'b1;
    @(posedge clk_i);
    smp_valid_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // pulses one frame and leaves the status word in rdata
  task automatic frame(input logic a, input logic [1:0] c1, input logic [2:0] c2);
    abs_i <= a;
    c1_i <= c1;
    c2_i <= c2;
    frame_valid_i <= 1'b1;
    @(posedge clk_i);
    frame_valid_i <= 1'b0;
    wb(1'b0, `ADDR_STATUS, 32'h0);
  endtask
  // one sample per serializer frame, all flagged bad
  task automatic stream(input int n);
    repeat (n)
    begin
      smp(16'h1234, 1'b1);
      repeat (2800) @(posedge clk_i);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `ADDR_LEVEL, 32'h0);
    check(rdata, 32'h0000_8002);
    wb(1'b0, 8'h40, 32'h0);
    check(rdata, 32'h0);
    frame(1'b1, 2'h2, 3'h3);
    check(rdata[7:0], 8'hC9);
    // the flag word leaves the pin first bit first; sample mid-slot
    for (int k = 0; k < 8; k++)
    begin
      repeat (k == 0 ? `FLAG_SLOT_CYC / 2 - 3 : `FLAG_SLOT_CYC) @(posedge clk_i);
      fbits = {fbits[6:0], flag_oe_n};
    end
    check(fbits, 8'hC9);
    frame(1'b0, 2'h3, 3'h5);
    check(rdata[7:0], 8'h79);
    frame(1'b1, 2'h1, 3'h4);
    check(rdata[7:0], 8'hB0);
    foreach (lv[i])
    begin
      wb(1'b1, `ADDR_LEVEL, lv[i][39:8]);
      repeat (400) @(posedge clk_i);
      wb(1'b0, `ADDR_STATUS, 32'h0);
      check(rdata[15:8], lv[i][7:0]);
    end
    wb(1'b1, `ADDR_DAC_FMT, `FMT_2X_EIAJ16);
    repeat (400) @(posedge clk_i);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    check(rdata[15:8], `GAIN_OVS);
    wb(1'b1, `ADDR_DAC_FMT, `FMT_4X_EIAJ16);
    wb(1'b1, `ADDR_CONFIG, 32'h3);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    check(rdata[17], 1'b1);
    wb(1'b1, `ADDR_CONFIG, 32'h0);
    wb(1'b1, `ADDR_DAC_FMT, `FMT_I2S_16_18);
    frame(1'b1, 2'h0, 3'h0);
    smp(16'h0100, 1'b0);
    smp(16'h0050, 1'b1);
    smp(16'h0300, 1'b0);
    check(fail_o, 1'b0);
    smp(16'h0300, 1'b0);
    frame(1'b1, 2'h0, 3'h0);
    check(rdata[2:1], 2'h1);
    repeat (60) @(posedge clk_i);
    check(fail_o, 1'b1);
    smp(16'h0050, 1'b1);
    smp(16'h0050, 1'b1);
    smp(16'h0300, 1'b0);
    smp(16'h0300, 1'b0);
    frame(1'b1, 2'h0, 3'h0);
    check(rdata[2:1], 2'h3);
    wb(1'b1, `ADDR_DAC_FMT, `FMT_ROM_I2S);
    stream(4);
    check(word[22:7], 16'h1234);
    check(ef_o, 1'b1);
    // peak byte is the magnitude bits just under the sign of the scaled sample
    check(q_peak_o, 16'h2424);
    wb(1'b1, `ADDR_DAC_FMT, 32'h3A);
    stream(3);
    check(word[22:7], 16'hEDCB);
    qdone_i <= 1'b1;
    @(posedge clk_i);
    qdone_i <= 1'b0;
    @(posedge clk_i);
    check(q_peak_o, 16'h0);
    pre_i <= 1'b1;
    wb(1'b1, `ADDR_DAC_FMT, `FMT_I2S_16_18);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    check(rdata[16], 1'b1);
    wb(1'b1, `ADDR_CONFIG, 32'h4);
    repeat (2) @(posedge clk_i);
    check(cfg5_o, 1'b1);
    wrap_up();
  end
  initial
  begin
    repeat (40000) @(posedge clk_i);
    failures++;
    wrap_up();
  end
endmodule // cd_audio_output_path_tb
`default_nettype wire

// ### tb/dac_receiver_model.sv
`timescale 1ns/1ps
`default_nettype none
module dac_receiver_model (
  // serial link
  input  wire logic        bclk_i,
  input  wire logic        ws_i,
  input  wire logic        data_i,
  // last channel word, first slot in bit 23
  output var  logic [23:0] word_o
);
  logic [23:0] shift_ff;
  logic        ws_ff;
  // latches on the rising bit clock like a real converter
  always @(posedge bclk_i)
  begin
    if (ws_i != ws_ff)
      word_o <= shift_ff;
    shift_ff <= {shift_ff[22:0], data_i};
    ws_ff <= ws_i;
  end
endmodule // dac_receiver_model
`default_nettype wire

// ### verilog/cd_audio_output_path.v
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cd_audio_output_path_map.vh"

module cd_audio_output_path #(
  parameter FAIL_CYC = `FAIL_CYC
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // corrected sample stream from the error corrector
  input  wire        smp_valid_i,
  input  wire [15:0] smp_left_i,
  input  wire [15:0] smp_right_i,
  input  wire        smp_bad_left_i,
  input  wire        smp_bad_right_i,
  // per-frame corrector results and subcode
  input  wire        frame_valid_i,
  input  wire        frame_abs_sync_i,
  input  wire [1:0]  frame_c1_i,
  input  wire [2:0]  frame_c2_i,
  input  wire        q_preemph_i,
  input  wire        q_read_done_i,
  // status pins
  output reg         error_flag_pin_o,
  output reg         error_flag_pin_oe_n_o,
  output reg         second_stage_fail_pin_o,
  output reg         config_pin_five_o,
  output reg  [15:0] q_peak_o,
  // dac serial link
  output reg         dac_bclk_o,
  output reg         dac_ws_o,
  output reg         dac_data_o,
  output reg         error_flag_output_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [15:0] midpoint;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {a[15], a} + {b[15], b};
      midpoint = s[16:1];
    end
  endfunction

  function [15:0] conceal;
    input [15:0] cur;
    input        cur_bad;
    input [15:0] nxt;
    input        nxt_bad;
    input [15:0] last;
    input        rom;
    begin
      if (!cur_bad || rom)
        conceal = cur;
      else if (nxt_bad)
        conceal = last;
      else
        conceal = midpoint(last, nxt);
    end
  endfunction

  // de-emphasis as a one-pole low-pass; bypass passes the sample through unchanged
  function [15:0] deemph;
    input [15:0] x;
    input [15:0] y_prev;
    input        on;
    reg   [16:0] d;
    begin
      d = {x[15], x} - {y_prev[15], y_prev};
      if (on)
        deemph = y_prev + {d[16], d[16:2]};
      else
        deemph = x;
    end
  endfunction

  // gain 0..128 linear, result carries two extra fraction bits
  function [17:0] scale;
    input [15:0] x;
    input [7:0]  g;
    reg   [24:0] p;
    begin
      p = $signed(x) * $signed({1'b0, g});
      scale = p[22:5];
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [1:0]  lvl_cmd_ff;
  reg [7:0]  fade_tgt_ff;
  reg [3:0]  fmt_ff;
  reg        ws_inv_ff;
  reg        data_inv_ff;
  reg [1:0]  nshift_ff;
  reg        deemph_pin5_ff;
  reg [7:0]  flag_word_ff;
  reg [7:0]  gain_ff;

  wire       fmt_rom  = (fmt_ff == `FMT_ROM_I2S) || (fmt_ff == `FMT_ROM_EIAJ);
  wire       fmt_4x   = (fmt_ff == `FMT_4X_EIAJ16) || (fmt_ff == `FMT_4X_EIAJ18) ||
                        (fmt_ff == `FMT_4X_I2S18);
  wire       fmt_2x   = (fmt_ff == `FMT_2X_EIAJ16) || (fmt_ff == `FMT_2X_EIAJ18) ||
                        (fmt_ff == `FMT_2X_I2S18);
  wire       fmt_i2s  = (fmt_ff == `FMT_ROM_I2S) || (fmt_ff == `FMT_I2S_16_18) ||
                        (fmt_ff == `FMT_4X_I2S18) || (fmt_ff == `FMT_2X_I2S18);
  wire       fmt_bad  = fmt_4x && (nshift_ff == 2'h3);
  wire       ovs_on   = fmt_4x || fmt_2x;
  wire       deemph_on = q_preemph_i && !deemph_pin5_ff;
  wire       fade_act = (lvl_cmd_ff == `LVL_FADE) || (lvl_cmd_ff == `LVL_ATTEN);
  wire [4:0] word_bits = (fmt_ff == `FMT_I2S_16_18) ? ((fade_act || deemph_on) ? 5'd18 : 5'd16)
                       : ((fmt_ff == `FMT_EIAJ18) || (fmt_ff == `FMT_4X_EIAJ18) ||
                          (fmt_ff == `FMT_4X_I2S18) || (fmt_ff == `FMT_2X_EIAJ18) ||
                          (fmt_ff == `FMT_2X_I2S18)) ? 5'd18 : 5'd16;

  wire       wb_req = cyc_i && stb_i && !ack_o;
  // a write lands on the ack edge, the one at which the master counts it done
  wire       wb_wr  = cyc_i && stb_i && we_i && ack_o;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o          <= 1'b0;
      dat_o          <= 32'h0000_0000;
      lvl_cmd_ff     <= `RST_LEVEL_CMD;
      fade_tgt_ff    <= `RST_FADE_TGT;
      fmt_ff         <= `RST_FORMAT;
      ws_inv_ff      <= 1'b0;
      data_inv_ff    <= 1'b0;
      nshift_ff      <= `RST_NSHIFT;
      deemph_pin5_ff <= 1'b0;
    end
    else
    begin
      ack_o <= wb_req;
      dat_o <= 32'h0000_0000;
      if (wb_wr)
      begin
        if (adr_i == `ADDR_LEVEL)
        begin
          if (sel_i[0])
            lvl_cmd_ff <= dat_i[1:0];
          if (sel_i[1])
            fade_tgt_ff <= (dat_i[15:8] > `GAIN_FULL) ? `GAIN_FULL : dat_i[15:8];
        end
        else if (adr_i == `ADDR_DAC_FMT)
        begin
          if (sel_i[0])
          begin
            fmt_ff      <= dat_i[3:0];
            ws_inv_ff   <= dat_i[4];
            data_inv_ff <= dat_i[5];
          end
        end
        else if (adr_i == `ADDR_CONFIG)
        begin
          if (sel_i[0])
          begin
            nshift_ff      <= dat_i[1:0];
            deemph_pin5_ff <= dat_i[2];
          end
        end
      end
      else if (wb_req && !we_i)
      begin
        if (adr_i == `ADDR_LEVEL)
          dat_o <= {16'h0000, fade_tgt_ff, 6'h00, lvl_cmd_ff};
        else if (adr_i == `ADDR_DAC_FMT)
          dat_o <= {26'h0, data_inv_ff, ws_inv_ff, fmt_ff};
        else if (adr_i == `ADDR_CONFIG)
          dat_o <= {29'h0, deemph_pin5_ff, nshift_ff};
        else if (adr_i == `ADDR_STATUS)
          dat_o <= {14'h0, fmt_bad, deemph_on, gain_ff, flag_word_ff};
        else if (adr_i == `ADDR_PEAK)
          dat_o <= {16'h0000, q_peak_o};
      end
    end
  end

  // ----------------------------------------------------------------
  // level controller
  // ----------------------------------------------------------------
  // the ramp is linear in gain, so 32/128 lands on -12 dB and 120/128
  // on -0.5 dB; finer dB steps would need a lookup table
  reg  [7:0]  gain_tgt;
  reg  [8:0]  ramp_cnt_ff;
  wire [31:0] ramp_raw = `MUTE_STEP_CYC >> nshift_ff;
  wire [8:0]  ramp_len = (ramp_raw != 32'h0000_0000) ? ramp_raw[8:0] : 9'd1;

  always @*
  begin
    if (lvl_cmd_ff == `LVL_MUTE)
      gain_tgt = `GAIN_MUTE;
    else if (lvl_cmd_ff == `LVL_ATTEN)
      gain_tgt = `GAIN_ATTEN;
    else if (lvl_cmd_ff == `LVL_FADE)
      gain_tgt = fade_tgt_ff;
    else
      gain_tgt = ovs_on ? `GAIN_OVS : `GAIN_FULL;
    if (ovs_on && gain_tgt > `GAIN_OVS)
      gain_tgt = `GAIN_OVS;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gain_ff     <= `GAIN_FULL;
      ramp_cnt_ff <= 9'd0;
    end
    else if (ramp_cnt_ff + 9'd1 >= ramp_len)
    begin
      ramp_cnt_ff <= 9'd0;
      if (gain_ff > gain_tgt)
        gain_ff <= gain_ff - 8'h01;
      else if (gain_ff < gain_tgt)
        gain_ff <= gain_ff + 8'h01;
    end
    else
      ramp_cnt_ff <= ramp_cnt_ff + 9'd1;
  end

  // ----------------------------------------------------------------
  // concealment, filter, gain and peak
  // ----------------------------------------------------------------
  // one sample of look-ahead is needed to know whether a bad sample
  // stands alone or starts a run
  reg  [15:0] cur_l_ff, cur_r_ff, last_l_ff, last_r_ff, de_l_ff, de_r_ff;
  reg         cur_bad_l_ff, cur_bad_r_ff;
  reg  [17:0] out_a_l_ff, out_a_r_ff, out_b_l_ff, out_b_r_ff;
  reg         out_bad_l_ff, out_bad_r_ff;
  reg         seen_interp_ff, seen_hold_ff, fail_evt;
  wire [15:0] con_l = conceal(cur_l_ff, cur_bad_l_ff, smp_left_i, smp_bad_left_i,
                              last_l_ff, fmt_rom);
  wire [15:0] con_r = conceal(cur_r_ff, cur_bad_r_ff, smp_right_i, smp_bad_right_i,
                              last_r_ff, fmt_rom);
  wire [15:0] fil_l = deemph(con_l, de_l_ff, deemph_on);
  wire [15:0] fil_r = deemph(con_r, de_r_ff, deemph_on);
  wire [17:0] lvl_l = scale(fil_l, gain_ff);
  wire [17:0] lvl_r = scale(fil_r, gain_ff);
  wire        hold_now = !fmt_rom && ((cur_bad_l_ff && smp_bad_left_i) ||
                                      (cur_bad_r_ff && smp_bad_right_i));
  wire        intp_now = !fmt_rom && ((cur_bad_l_ff && !smp_bad_left_i) ||
                                      (cur_bad_r_ff && !smp_bad_right_i));

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur_l_ff <= 16'h0000;  cur_r_ff <= 16'h0000;
      last_l_ff <= 16'h0000; last_r_ff <= 16'h0000;
      de_l_ff <= 16'h0000;   de_r_ff <= 16'h0000;
      cur_bad_l_ff <= 1'b0;  cur_bad_r_ff <= 1'b0;
      out_a_l_ff <= 18'h00000; out_a_r_ff <= 18'h00000;
      out_b_l_ff <= 18'h00000; out_b_r_ff <= 18'h00000;
      out_bad_l_ff <= 1'b0;  out_bad_r_ff <= 1'b0;
      fail_evt <= 1'b0;
      q_peak_o <= 16'h0000;
    end
    else
    begin
      fail_evt <= smp_valid_i && (cur_bad_l_ff || cur_bad_r_ff);
      if (smp_valid_i)
      begin
        cur_l_ff <= smp_left_i;          cur_r_ff <= smp_right_i;
        cur_bad_l_ff <= smp_bad_left_i;  cur_bad_r_ff <= smp_bad_right_i;
        last_l_ff <= con_l;              last_r_ff <= con_r;
        de_l_ff <= fil_l;                de_r_ff <= fil_r;
        out_a_l_ff <= out_b_l_ff;        out_a_r_ff <= out_b_r_ff;
        out_b_l_ff <= lvl_l;             out_b_r_ff <= lvl_r;
        out_bad_l_ff <= cur_bad_l_ff;    out_bad_r_ff <= cur_bad_r_ff;
      end
      if (q_read_done_i)
        q_peak_o <= 16'h0000;
      else if (smp_valid_i)
      begin
        if (!lvl_l[17] && lvl_l[16:9] > q_peak_o[7:0])
          q_peak_o[7:0] <= lvl_l[16:9];
        if (!lvl_r[17] && lvl_r[16:9] > q_peak_o[15:8])
          q_peak_o[15:8] <= lvl_r[16:9];
      end
    end
  end

  // ----------------------------------------------------------------
  // per-frame flag word and serial flag pin
  // ----------------------------------------------------------------
  reg  [7:0]  flag_sh_ff;
  reg  [3:0]  flag_left_ff;
  reg  [8:0]  flag_cnt_ff;
  wire [2:0]  c2_code = (frame_c2_i > 3'd4) ? 3'h7 : frame_c2_i;
  wire [31:0] slot_raw = `FLAG_SLOT_CYC >> nshift_ff;
  wire [8:0]  slot_len = slot_raw[8:0];

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_word_ff <= 8'h00;
      flag_sh_ff <= 8'hFF;
      flag_left_ff <= 4'h0;
      flag_cnt_ff <= 9'd0;
      seen_interp_ff <= 1'b0;
      seen_hold_ff <= 1'b0;
      error_flag_pin_o <= 1'b0;
      error_flag_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      error_flag_pin_o <= 1'b0;
      if (frame_valid_i)
      begin
        flag_word_ff[`FB_ONE]   <= frame_abs_sync_i;
        flag_word_ff[`FB_TWO]   <= frame_c1_i[1];
        flag_word_ff[`FB_THREE] <= frame_c1_i[0];
        flag_word_ff[`FB_FOUR]  <= c2_code[2];
        flag_word_ff[`FB_FIVE]  <= c2_code[1];
        flag_word_ff[`FB_EIGHT] <= c2_code[0];
        flag_word_ff[`FB_SIX]   <= seen_hold_ff || (smp_valid_i && hold_now);
        flag_word_ff[`FB_SEVEN] <= seen_interp_ff || (smp_valid_i && intp_now);
        flag_sh_ff <= {frame_abs_sync_i, frame_c1_i, c2_code[2:1],
                       seen_hold_ff || (smp_valid_i && hold_now),
                       seen_interp_ff || (smp_valid_i && intp_now), c2_code[0]};
        flag_left_ff <= 4'h8;
        flag_cnt_ff <= 9'd0;
        seen_hold_ff <= 1'b0;
        seen_interp_ff <= 1'b0;
      end
      else
      begin
        if (smp_valid_i && hold_now)
          seen_hold_ff <= 1'b1;
        if (smp_valid_i && intp_now)
          seen_interp_ff <= 1'b1;
        if (flag_left_ff != 4'h0)
        begin
          if (flag_cnt_ff + 9'd1 >= slot_len)
          begin
            flag_cnt_ff <= 9'd0;
            flag_sh_ff <= {flag_sh_ff[6:0], 1'b1};
            flag_left_ff <= flag_left_ff - 4'h1;
          end
          else
            flag_cnt_ff <= flag_cnt_ff + 9'd1;
        end
      end
      // open drain: pull low for a zero, release for a one or idle
      error_flag_pin_oe_n_o <= !((flag_left_ff != 4'h0) && !flag_sh_ff[7]);
    end
  end

  // ----------------------------------------------------------------
  // second-stage failure pulse
  // ----------------------------------------------------------------
  reg  [15:0] fail_cnt_ff;
  wire [31:0] fail_raw = FAIL_CYC >> nshift_ff;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fail_cnt_ff <= 16'h0000;
      second_stage_fail_pin_o <= 1'b1;
      config_pin_five_o <= 1'b0;
    end
    else
    begin
      config_pin_five_o <= deemph_pin5_ff && q_preemph_i;
      if (fail_evt)
        fail_cnt_ff <= fail_raw[15:0];
      else if (fail_cnt_ff != 16'h0000)
        fail_cnt_ff <= fail_cnt_ff - 16'h0001;
      second_stage_fail_pin_o <= !(fail_evt || fail_cnt_ff > 16'h0001);
    end
  end

  // ----------------------------------------------------------------
  // dac serialiser
  // ----------------------------------------------------------------
  // bit clock is a divider of clk_i; 48 bit slots per output word pair
  reg  [5:0]  half_cnt_ff;
  reg  [5:0]  slot_ff;
  reg  [1:0]  sub_ff;
  reg  [23:0] word_l_ff, word_r_ff;
  wire [1:0]  rate_sh = fmt_4x ? 2'd2 : (fmt_2x ? 2'd1 : 2'd0);
  // the shift needs three bits: n = 8 at four-times rate shifts by five
  wire [2:0]  bclk_sh = {1'b0, nshift_ff} + {1'b0, rate_sh};
  wire [31:0] half_raw = `BCLK_HALF_CYC >> bclk_sh;
  wire [5:0]  half_len = (half_raw != 32'h0000_0000) ? half_raw[5:0] : 6'd1;
  wire [1:0]  sub_max = fmt_4x ? 2'd3 : (fmt_2x ? 2'd1 : 2'd0);
  wire        left_half = (slot_ff < 6'd`SLOTS_PER_CH);
  wire [5:0]  pos_right = slot_ff - 6'd`SLOTS_PER_CH;
  wire [4:0]  pos = left_half ? slot_ff[4:0] : pos_right[4:0];
  wire [23:0] word = left_half ? word_l_ff : word_r_ff;
  wire [4:0]  rj_start = 5'd`SLOTS_PER_CH - word_bits;
  reg         bit_val;
  reg  [19:0] ip_l, ip_r;

  always @*
  begin
    bit_val = 1'b0;
    if (fmt_i2s)
    begin
      if (pos >= 5'd1 && pos <= word_bits)
        bit_val = word[5'd24 - pos];
    end
    else if (pos >= rj_start)
      bit_val = word[5'd23 - (pos - rj_start)];
    // linear steps between the last two samples form the oversampled stream
    ip_l = $signed({{2{out_a_l_ff[17]}}, out_a_l_ff}) +
           (($signed({{2{out_b_l_ff[17]}}, out_b_l_ff}) -
             $signed({{2{out_a_l_ff[17]}}, out_a_l_ff})) * $signed({1'b0, sub_ff})
            >>> rate_sh);
    ip_r = $signed({{2{out_a_r_ff[17]}}, out_a_r_ff}) +
           (($signed({{2{out_b_r_ff[17]}}, out_b_r_ff}) -
             $signed({{2{out_a_r_ff[17]}}, out_a_r_ff})) * $signed({1'b0, sub_ff})
            >>> rate_sh);
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      half_cnt_ff <= 6'd0;
      slot_ff <= 6'd0;
      sub_ff <= 2'd0;
      word_l_ff <= 24'h000000;
      word_r_ff <= 24'h000000;
      dac_bclk_o <= 1'b0;
      dac_ws_o <= 1'b0;
      dac_data_o <= 1'b0;
      error_flag_output_o <= 1'b0;
    end
    else if (half_cnt_ff + 6'd1 >= half_len)
    begin
      half_cnt_ff <= 6'd0;
      dac_bclk_o <= !dac_bclk_o;
      if (dac_bclk_o)
      begin
        // falling edge: data and word select change, the dac samples on rising
        dac_data_o <= bit_val ^ data_inv_ff;
        dac_ws_o <= (fmt_i2s ? !left_half : left_half) ^ ws_inv_ff;
        error_flag_output_o <= fmt_rom && (left_half ? out_bad_l_ff : out_bad_r_ff);
        if (slot_ff == 6'd47)
        begin
          slot_ff <= 6'd0;
          sub_ff <= (sub_ff >= sub_max) ? 2'd0 : sub_ff + 2'd1;
          word_l_ff <= fmt_bad ? 24'h000000 : {ip_l[17:0], 6'h00};
          word_r_ff <= fmt_bad ? 24'h000000 : {ip_r[17:0], 6'h00};
        end
        else
          slot_ff <= slot_ff + 6'd1;
      end
    end
    else
      half_cnt_ff <= half_cnt_ff + 6'd1;
  end

endmodule // cd_audio_output_path

`default_nettype wire

// ### verilog/cd_audio_output_path_map.vh
`ifndef CD_AUDIO_OUTPUT_PATH_MAP_VH
`define CD_AUDIO_OUTPUT_PATH_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADDR_LEVEL       8'h00
`define ADDR_DAC_FMT     8'h04
`define ADDR_CONFIG      8'h08
`define ADDR_STATUS      8'h0C
`define ADDR_PEAK        8'h10

// ----------------------------------------------------------------
// level controller commands
// ----------------------------------------------------------------
`define LVL_MUTE         2'h0
`define LVL_ATTEN        2'h1
`define LVL_FULL         2'h2
`define LVL_FADE         2'h3
`define GAIN_FULL        8'h80
`define GAIN_OVS         8'h78
`define GAIN_ATTEN       8'h20
`define GAIN_MUTE        8'h00

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_LEVEL_CMD    2'h2
`define RST_FADE_TGT     8'h80
`define RST_FORMAT       4'hE
`define RST_NSHIFT       2'h0

// ----------------------------------------------------------------
// dac format codes
// ----------------------------------------------------------------
`define FMT_ROM_I2S      4'hA
`define FMT_ROM_EIAJ     4'hB
`define FMT_I2S_16_18    4'hE
`define FMT_EIAJ16       4'h2
`define FMT_EIAJ18       4'h6
`define FMT_4X_EIAJ16    4'h0
`define FMT_4X_EIAJ18    4'h4
`define FMT_4X_I2S18     4'hC
`define FMT_2X_EIAJ16    4'h3
`define FMT_2X_EIAJ18    4'h7
`define FMT_2X_I2S18     4'hF

// ----------------------------------------------------------------
// flag word bit positions (flag_bit_one sent first)
// ----------------------------------------------------------------
`define FB_ONE           7
`define FB_TWO           6
`define FB_THREE         5
`define FB_FOUR          4
`define FB_FIVE          3
`define FB_SIX           2
`define FB_SEVEN         1
`define FB_EIGHT         0

// ----------------------------------------------------------------
// timing (clock 125 MHz)
// ----------------------------------------------------------------
`define CLK_MHZ          125
`define FAIL_US          140
`define FAIL_CYC         (`FAIL_US * `CLK_MHZ)
`define MUTE_US          3
`define MUTE_STEP_CYC    ((`MUTE_US * `CLK_MHZ) / 128)
`define BCLK_BASE_KHZ    2117
`define BCLK_HALF_CYC    ((`CLK_MHZ * 1000) / (2 * `BCLK_BASE_KHZ))
`define FLAG_SLOT_CYC    250
`define SLOTS_PER_CH     24

`endif
